// file: verilog/bglc_pkg.sv
// Purpose: Constants for the baud rate generator and line coder block.
// Assumes: 8-bit register port, one 100 MHz clock.
// Notes: Behaviour list below.
//
// Behaviour
// - Two 8-bit constant bytes feed a 16-bit down counter and toggling output.
// - On start the output is set high and the counter loaded.
// - At zero the output toggles and the counter reloads, forever.
// - Software reads the time constant back as low and high bytes.
// - A new constant reaches the counter only at reload or start.
// - Generator output may drive the shared clock pin when no clock uses it.
// - Source select 0 takes the clock pin, 1 takes the bus clock.
// - Runs only while enabled; hardware reset clears enable, soft reset not.
// - Enable is synchronised to the generator clock, delaying the start.
// - Clearing enable stops the generator at once.
// - Bit rate is clock over two times mode times constant plus two.
// - Hardware reset selects the clock pin as generator source.
// - A two-bit field picks NRZ, NRZI, FM1 or FM0 in x1 modes.
// - Line coding stays active while transmitter or receiver idles.
// - NRZ sends one high and zero low for the whole cell.
// - NRZI keeps level for one and inverts it for zero.
// - FM1 toggles every boundary and mid-cell for a one.
// - NRZ/NRZI receive on one edge, FM on both; transmit mid on other.
// - SDLC NRZI mark idle forces the data pin high after closing flag.
`default_nettype none
package bglc_pkg;
  localparam int BGLC_DW = 8;
  localparam int BGLC_AW = 4;
  localparam int BGLC_TCW = 16;
  localparam int BGLC_DIVW = 7;
  // Register addresses
  localparam logic [3:0] BGLC_A_FMT = 4'hA;
  localparam logic [3:0] BGLC_A_MODE = 4'hB;
  localparam logic [3:0] BGLC_A_TCL = 4'hC;
  localparam logic [3:0] BGLC_A_TCH = 4'hD;
  localparam logic [3:0] BGLC_A_MISC = 4'hE;
  localparam logic [3:0] BGLC_A_STAT = 4'hF;
  // Field positions
  localparam int BGLC_MISC_EN = 0;
  localparam int BGLC_MISC_SRC = 1;
  localparam int BGLC_FMT_MARK = 3;
  localparam int BGLC_FMT_ENC_LO = 5;
  localparam int BGLC_FMT_ENC_HI = 6;
  localparam int BGLC_MODE_SDLC = 0;
  localparam int BGLC_MODE_TXPIN = 1;
  localparam int BGLC_MODE_RXPIN = 2;
  localparam int BGLC_MODE_CM_LO = 3;
  localparam int BGLC_MODE_CM_HI = 4;
  localparam int BGLC_MODE_DRV = 5;
  // Reset values
  localparam logic [7:0] BGLC_RST_REG = 8'h00;
  localparam logic [15:0] BGLC_RST_TC = 16'h0000;
  // Clock mode factors
  localparam logic [6:0] BGLC_CM_X1 = 7'h01;
  localparam logic [6:0] BGLC_CM_X16 = 7'h10;
  localparam logic [6:0] BGLC_CM_X32 = 7'h20;
  localparam logic [6:0] BGLC_CM_X64 = 7'h40;
  typedef enum logic [1:0] {BGLC_NRZ, BGLC_NRZI, BGLC_FM1, BGLC_FM0} bglc_enc_e;
endpackage
`default_nettype wire

// file: verilog/bglc_sync3.sv
// Purpose: Three-flop input synchroniser with agreement filter.
// Assumes: Input is asynchronous to clk.
// Notes: Output follows once second and third flops agree.
`default_nettype none
module bglc_sync3 (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Signal
  input wire logic din,
  output logic dout
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic dout_ff;
  wire agree = (s2_ff == s3_ff);
  wire nxt_dout = agree ? s3_ff : dout_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      dout_ff <= 1'b0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      dout_ff <= nxt_dout;
    end
  end

  assign dout = dout_ff;
endmodule
`default_nettype wire

// file: verilog/bglc_top.sv
// Purpose: Baud rate generator and serial line coder for one channel.
// Assumes: Single 100 MHz clock; pins sampled through three flops.
// Notes: Generator clock is either every bus cycle or pin rising edges.
//
// Added by the designer: the register addresses and the strobed register port.
`default_nettype none
module bglc_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_rst,
  // Register port
  input wire logic [bglc_pkg::BGLC_AW-1:0] reg_addr,
  input wire logic [bglc_pkg::BGLC_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [bglc_pkg::BGLC_DW-1:0] reg_rdata,
  // Clock pins
  input wire logic shared_rx_clock_pin,
  output logic shared_tx_clock_pin_o,
  output logic shared_tx_clock_pin_oe,
  // Data pins
  input wire logic rxd_pin,
  output logic txd_pin,
  // Transmitter side
  input wire logic tx_bit,
  input wire logic sdlc_flag_end,
  output logic tx_take,
  output logic tx_bit_clock,
  // Receiver side
  output logic rx_bit,
  output logic rx_bit_valid
);
  import bglc_pkg::*;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [7:0] tc_lo_ff;
  logic [7:0] tc_hi_ff;
  logic [7:0] misc_ff;
  logic [7:0] fmt_ff;
  logic [7:0] mode_ff;
  logic [7:0] rdata_ff;

  wire wr_fmt = reg_wr && (reg_addr == BGLC_A_FMT);
  wire wr_mode = reg_wr && (reg_addr == BGLC_A_MODE);
  wire wr_tcl = reg_wr && (reg_addr == BGLC_A_TCL);
  wire wr_tch = reg_wr && (reg_addr == BGLC_A_TCH);
  wire wr_misc = reg_wr && (reg_addr == BGLC_A_MISC);

  wire [15:0] tc_val = {tc_hi_ff, tc_lo_ff};
  wire enable = misc_ff[BGLC_MISC_EN];
  wire src_bus = misc_ff[BGLC_MISC_SRC];
  wire mark_idle = fmt_ff[BGLC_FMT_MARK];
  wire [1:0] enc_bits = fmt_ff[BGLC_FMT_ENC_HI:BGLC_FMT_ENC_LO];
  bglc_enc_e enc;
  assign enc = bglc_enc_e'(enc_bits);
  wire sdlc = mode_ff[BGLC_MODE_SDLC];
  wire tx_from_pin = mode_ff[BGLC_MODE_TXPIN];
  wire rx_from_pin = mode_ff[BGLC_MODE_RXPIN];
  wire pin_drive = mode_ff[BGLC_MODE_DRV];
  wire [1:0] cm_bits = mode_ff[BGLC_MODE_CM_HI:BGLC_MODE_CM_LO];

  // Hardware reset only: soft reset must not stop the generator
  always_ff @(posedge clk) begin
    if (rst) begin
      misc_ff <= BGLC_RST_REG;
    end else if (wr_misc) begin
      misc_ff <= reg_wdata;
    end
  end

  // Constant writes touch storage only, counter picks them up on reload
  always_ff @(posedge clk) begin
    if (rst) begin
      tc_lo_ff <= BGLC_RST_TC[7:0];
      tc_hi_ff <= BGLC_RST_TC[15:8];
    end else begin
      if (wr_tcl) begin
        tc_lo_ff <= reg_wdata;
      end
      if (wr_tch) begin
        tc_hi_ff <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst || soft_rst) begin
      fmt_ff <= BGLC_RST_REG;
      mode_ff <= BGLC_RST_REG;
    end else begin
      if (wr_fmt) begin
        fmt_ff <= reg_wdata;
      end
      if (wr_mode) begin
        mode_ff <= reg_wdata;
      end
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic clk_pin_s;
  logic rxd_s;
  logic clk_pin_prev_ff;

  bglc_sync3 u_sync_clk (
    .clk(clk),
    .rst(rst),
    .din(shared_rx_clock_pin),
    .dout(clk_pin_s)
  );

  bglc_sync3 u_sync_rxd (
    .clk(clk),
    .rst(rst),
    .din(rxd_pin),
    .dout(rxd_s)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      clk_pin_prev_ff <= 1'b0;
    end else begin
      clk_pin_prev_ff <= clk_pin_s;
    end
  end

  wire pin_rise = clk_pin_s && !clk_pin_prev_ff;
  wire gen_tick = src_bus ? 1'b1 : pin_rise;

  // ----------------------------------------
  // Rate generator
  // ----------------------------------------
  logic [1:0] start_ff;
  logic [15:0] cnt_ff;
  logic load_ph_ff;
  logic gen_out_ff;

  // Start takes two generator ticks, stop is immediate
  wire [1:0] nxt_start = !enable ? 2'b00 :
                         gen_tick ? {start_ff[0], 1'b1} : start_ff;
  wire run = start_ff[1] && enable;
  wire do_load = run && gen_tick && load_ph_ff;
  wire at_zero = run && gen_tick && !load_ph_ff && (cnt_ff == BGLC_RST_TC);
  wire do_dec = run && gen_tick && !load_ph_ff && (cnt_ff != BGLC_RST_TC);
  wire gen_fall = at_zero && gen_out_ff;
  wire gen_rise = at_zero && !gen_out_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      start_ff <= 2'b00;
    end else begin
      start_ff <= nxt_start;
    end
  end

  // Load phase costs one tick, so a half period is constant plus two ticks
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      gen_out_ff <= 1'b1;
      load_ph_ff <= 1'b1;
      cnt_ff <= BGLC_RST_TC;
    end else if (do_load) begin
      cnt_ff <= tc_val;
      load_ph_ff <= 1'b0;
    end else if (at_zero) begin
      gen_out_ff <= !gen_out_ff;
      load_ph_ff <= 1'b1;
    end else if (do_dec) begin
      cnt_ff <= cnt_ff - 16'h0001;
    end
  end

  // ----------------------------------------
  // Bit cell timing
  // ----------------------------------------
  logic [6:0] div_ff;
  wire [6:0] cm_val = (cm_bits == 2'b00) ? BGLC_CM_X1 :
                      (cm_bits == 2'b01) ? BGLC_CM_X16 :
                      (cm_bits == 2'b10) ? BGLC_CM_X32 : BGLC_CM_X64;
  wire [6:0] cm_last = cm_val - BGLC_CM_X1;
  wire [6:0] cm_half = cm_val >> 1;
  // Boundary on falling generator edge, mid-cell on rising edge
  // At or past the last count, so a smaller mode written mid-cell cannot skip a wrap
  wire bnd = gen_fall && (div_ff >= cm_last);
  wire mid = gen_rise && (div_ff == cm_half);

  always_ff @(posedge clk) begin
    if (rst || !run) begin
      div_ff <= 7'h00;
    end else if (gen_fall) begin
      div_ff <= bnd ? 7'h00 : div_ff + BGLC_CM_X1;
    end
  end

  // ----------------------------------------
  // Transmit encoder
  // ----------------------------------------
  logic txd_ff;
  logic cur_bit_ff;
  logic take_ff;
  logic flag_pend_ff;
  logic force_ff;

  wire force_arm = sdlc && (enc == BGLC_NRZI) && mark_idle;
  logic nxt_txd;

  // Coding runs whether or not a transmitter is active
  always_comb begin
    nxt_txd = txd_ff;
    if (force_ff) begin
      nxt_txd = 1'b1;
    end else if (bnd) begin
      unique case (enc)
        BGLC_NRZ: nxt_txd = tx_bit;
        BGLC_NRZI: nxt_txd = tx_bit ? txd_ff : !txd_ff;
        BGLC_FM1: nxt_txd = !txd_ff;
        BGLC_FM0: nxt_txd = !txd_ff;
      endcase
    end else if (mid) begin
      unique case (enc)
        BGLC_NRZ: nxt_txd = txd_ff;
        BGLC_NRZI: nxt_txd = txd_ff;
        BGLC_FM1: nxt_txd = cur_bit_ff ? !txd_ff : txd_ff;
        BGLC_FM0: nxt_txd = cur_bit_ff ? txd_ff : !txd_ff;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst || soft_rst) begin
      txd_ff <= 1'b1;
      cur_bit_ff <= 1'b0;
      take_ff <= 1'b0;
    end else begin
      txd_ff <= nxt_txd;
      take_ff <= bnd;
      if (bnd) begin
        cur_bit_ff <= tx_bit;
      end
    end
  end

  // Force waits for the falling edge after the closing flag's last bit
  always_ff @(posedge clk) begin
    if (rst || soft_rst || !force_arm) begin
      flag_pend_ff <= 1'b0;
      force_ff <= 1'b0;
    end else if (sdlc_flag_end) begin
      flag_pend_ff <= 1'b1;
    end else if (flag_pend_ff && gen_fall) begin
      flag_pend_ff <= 1'b0;
      force_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // Receive decoder
  // ----------------------------------------
  logic first_ff;
  logic prev_ff;
  logic rx_bit_ff;
  logic rx_val_ff;
  wire fm = (enc == BGLC_FM1) || (enc == BGLC_FM0);
  // Synchronised level is the half cell before the edge
  wire fm_bit = (enc == BGLC_FM1) ? (first_ff != rxd_s) : (first_ff == rxd_s);
  wire nrz_bit = (enc == BGLC_NRZ) ? rxd_s : (rxd_s == prev_ff);

  always_ff @(posedge clk) begin
    if (rst || soft_rst) begin
      first_ff <= 1'b1;
      prev_ff <= 1'b1;
      rx_bit_ff <= 1'b0;
      rx_val_ff <= 1'b0;
    end else begin
      rx_val_ff <= 1'b0;
      if (mid) begin
        first_ff <= rxd_s;
        if (!fm) begin
          prev_ff <= rxd_s;
          rx_bit_ff <= nrz_bit;
          rx_val_ff <= 1'b1;
        end
      end
      if (bnd && fm) begin
        rx_bit_ff <= fm_bit;
        rx_val_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Clock pin drive and read port
  // ----------------------------------------
  logic pin_o_ff;
  logic pin_oe_ff;
  wire nxt_pin_oe = pin_drive && !tx_from_pin && !rx_from_pin;

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_o_ff <= 1'b1;
      pin_oe_ff <= 1'b0;
    end else begin
      pin_o_ff <= gen_out_ff;
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  wire [7:0] stat_val = {4'h0, force_ff, txd_ff, run, gen_out_ff};
  wire [7:0] rd_mux = (reg_addr == BGLC_A_FMT) ? fmt_ff :
                      (reg_addr == BGLC_A_MODE) ? mode_ff :
                      (reg_addr == BGLC_A_TCL) ? tc_lo_ff :
                      (reg_addr == BGLC_A_TCH) ? tc_hi_ff :
                      (reg_addr == BGLC_A_MISC) ? misc_ff :
                      (reg_addr == BGLC_A_STAT) ? stat_val : BGLC_RST_REG;

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= BGLC_RST_REG;
    end else begin
      rdata_ff <= reg_rd ? rd_mux : BGLC_RST_REG;
    end
  end

  assign reg_rdata = rdata_ff;
  assign shared_tx_clock_pin_o = pin_o_ff;
  assign shared_tx_clock_pin_oe = pin_oe_ff;
  assign txd_pin = txd_ff;
  assign tx_take = take_ff;
  assign tx_bit_clock = gen_out_ff;
  assign rx_bit = rx_bit_ff;
  assign rx_bit_valid = rx_val_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  stop_now_a: assert property (
    !enable |=> gen_out_ff && load_ph_ff)
    else $error("generator runs while disabled");

  start_delay_a: assert property (
    $rose(enable) && src_bus |=> !run ##1 run)
    else $error("start delay wrong");

  start_high_a: assert property (
    $rose(run) |-> gen_out_ff && load_ph_ff)
    else $error("start state wrong");

  toggle_zero_a: assert property (
    at_zero && !soft_rst |=> (gen_out_ff != $past(gen_out_ff)) && load_ph_ff)
    else $error("no toggle at zero");

  reload_tc_a: assert property (
    do_load && !wr_tcl && !wr_tch |=> cnt_ff == tc_val)
    else $error("reload value wrong");

  tc_write_only_a: assert property (
    (wr_tcl || wr_tch) && !gen_tick && run |=> $stable(cnt_ff))
    else $error("write changed counter");

  readback_lo_a: assert property (
    reg_rd && reg_addr == BGLC_A_TCL && !wr_tcl |=> reg_rdata == $past(tc_lo_ff))
    else $error("low readback wrong");

  src_reset_a: assert property (
    $past(rst) |-> !src_bus && !enable)
    else $error("reset source wrong");

  nrz_level_a: assert property (
    bnd && enc == BGLC_NRZ && !force_ff && !soft_rst |=> txd_pin == $past(tx_bit))
    else $error("nrz level wrong");

  nrzi_zero_a: assert property (
    bnd && enc == BGLC_NRZI && !tx_bit && !force_ff && !soft_rst
    |=> txd_pin != $past(txd_pin))
    else $error("nrzi zero not inverted");

  fm_boundary_a: assert property (
    bnd && fm && !force_ff && !soft_rst |=> txd_pin != $past(txd_pin))
    else $error("fm boundary missing");

  pin_drive_a: assert property (
    pin_drive && (tx_from_pin || rx_from_pin) && !soft_rst |=> !shared_tx_clock_pin_oe)
    else $error("clock pin driven while in use");

  force_high_a: assert property (
    force_ff |=> txd_pin)
    else $error("forced line not high");
endmodule
`default_nettype wire

// file: testbench/bglc_line_model.sv
// Purpose: Far-side line model: loops the line back and makes a pin clock.
// Assumes: Bench clock of 100 MHz.
// Notes: Pin clock stands low unless asked to run.
`default_nettype none
module bglc_line_model (
  // Clock
  input wire logic clk,
  // Line
  input wire logic txd_pin,
  output logic rxd_pin,
  // Pin clock
  input wire logic pin_clk_run,
  output logic shared_rx_clock_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div_cnt;
  initial begin
    rxd_pin = 1'b1;
    shared_rx_clock_pin = 1'b0;
    div_cnt = 3'h0;
  end
  // One cycle of wire delay on the loopback
  always @(posedge clk) begin
    rxd_pin <= txd_pin;
  end
  // Ten-cycle period, held still while stopped
  always @(posedge clk) begin
    if (!pin_clk_run) begin
      div_cnt <= 3'h0;
      shared_rx_clock_pin <= 1'b0;
    end else if (div_cnt == 3'h4) begin
      div_cnt <= 3'h0;
      shared_rx_clock_pin <= !shared_rx_clock_pin;
    end else begin
      div_cnt <= div_cnt + 3'h1;
    end
  end
endmodule
`default_nettype wire

// file: testbench/baud_generator_line_coder_tb.sv
// Purpose: Self-checking bench for the rate generator and line coder.
// Assumes: Bus clock source for most tests; small time constants.
// Notes: Monitors sample on the falling clock edge to stay clear of races.
`default_nettype none
module baud_generator_line_coder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bglc_pkg::*;
  logic clk = 0, rst = 1, soft_rst = 0, reg_wr = 0, reg_rd = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic rxd_pin, shared_rx_clock_pin, pin_o, pin_oe, txd_pin, tx_take, tx_bit_clock;
  logic tx_bit = 0, sdlc_flag_end = 0, pin_run = 0, rx_bit, rx_bit_valid;
  logic mon_en = 0, take_d = 0, rd_seen = 0, line_lvl, bnd_exp, mid_exp, gen_d = 1;
  logic [7:0] rdq[$];
  logic [1:0] txq[$];
  logic rxq[$];
  bglc_enc_e enc = BGLC_NRZ;
  int failures = 0, total_checks = 0, tc, tc2, n, k, mid_cnt = 0;
  logic [15:0] val;
  logic [7:0] mode_list[4] = '{8'h20, 8'h22, 8'h24, 8'h00};
  time t0;
  always #5 clk = !clk;
  bglc_top uut (.clk(clk), .rst(rst), .soft_rst(soft_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .shared_rx_clock_pin(shared_rx_clock_pin), .shared_tx_clock_pin_o(pin_o),
    .shared_tx_clock_pin_oe(pin_oe), .rxd_pin(rxd_pin), .txd_pin(txd_pin),
    .tx_bit(tx_bit), .sdlc_flag_end(sdlc_flag_end), .tx_take(tx_take),
    .tx_bit_clock(tx_bit_clock), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid));
  bglc_line_model far_end (.clk(clk), .txd_pin(txd_pin), .rxd_pin(rxd_pin),
    .pin_clk_run(pin_run), .shared_rx_clock_pin(shared_rx_clock_pin));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rdq.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  // Negedges until the generator output next changes
  task automatic gap(output int c);
    logic v;
    v = tx_bit_clock;
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (tx_bit_clock === v && c < 2000);
  endtask
  task automatic nxt_bit();
    logic b, bl;
    b = 1'($urandom_range(1));
    case (enc)
      BGLC_NRZ: bl = b;
      BGLC_NRZI: bl = b ? line_lvl : !line_lvl;
      default: bl = !line_lvl;
    endcase
    line_lvl = bl ^ ((enc == BGLC_FM1) && b) ^ ((enc == BGLC_FM0) && !b);
    txq.push_back({bl, line_lvl});
    rxq.push_back(b);
    tx_bit <= b;
  endtask
  task automatic test_done();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------
  // Driver and monitors
  // ----------------------------------------
  always @(posedge clk) begin
    if (mon_en && take_d) nxt_bit();
  end
  always @(negedge clk) begin
    take_d = (tx_take === 1'b1);
    if (!rst) chk(16'(pin_o), 16'(gen_d));
    gen_d = tx_bit_clock;
    if (rd_seen) chk(16'(reg_rdata), 16'(rdq.pop_front()));
    rd_seen = (reg_rd === 1'b1);
    if (mid_cnt > 0) begin
      mid_cnt--;
      if (mid_cnt == 0) chk(16'(txd_pin), 16'(mid_exp));
    end
    if (mon_en && take_d && txq.size() > 0) begin
      {bnd_exp, mid_exp} = txq.pop_front();
      chk(16'(txd_pin), 16'(bnd_exp));
      mid_cnt = tc + 4;
    end
    if (mon_en && rx_bit_valid === 1'b1 && rxq.size() > 0)
      chk(16'(rx_bit), 16'(rxq.pop_front()));
  end
  initial begin
    #300us;
    failures++;
    test_done();
  end
  initial begin
    void'($urandom(85761));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(BGLC_A_TCL, 8'h00);
    rd(BGLC_A_MISC, 8'h00);
    wr(4'h0, 8'hFF);
    rd(4'h0, 8'h00);
    chk(16'(tx_bit_clock), 16'h0001);
    $display("test reset done");
    val = 16'($urandom);
    wr(BGLC_A_TCL, val[7:0]);
    wr(BGLC_A_TCH, val[15:8]);
    rd(BGLC_A_TCL, val[7:0]);
    rd(BGLC_A_TCH, val[15:8]);
    tc = 4 + $urandom_range(5);
    wr(BGLC_A_TCL, 8'(tc));
    wr(BGLC_A_TCH, 8'h00);
    wr(BGLC_A_MISC, 8'h02);
    wr(BGLC_A_MISC, 8'h03);
    gap(n);
    chk(16'(n > tc + 2 && n < tc + 8), 16'h0001);
    gap(n);
    chk(16'(n), 16'(tc + 2));
    $display("test period done");
    tc2 = tc + 3;
    gap(n);
    repeat (2) @(posedge clk);
    wr(BGLC_A_TCL, 8'(tc2));
    gap(n);
    chk(16'(n <= tc + 2), 16'h0001);
    gap(n);
    chk(16'(n), 16'(tc2 + 2));
    tc = tc2;
    @(posedge clk);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    gap(n);
    gap(n);
    chk(16'(n), 16'(tc + 2));
    rd(BGLC_A_MISC, 8'h03);
    wr(BGLC_A_MISC, 8'h02);
    // Output returns high one edge after the enable clears
    @(posedge clk);
    k = 0;
    repeat (3 * tc + 9) begin
      @(negedge clk);
      k += (tx_bit_clock !== 1'b1);
    end
    chk(16'(k), 16'h0000);
    $display("test stop done");
    wr(BGLC_A_TCL, 8'h02);
    pin_run <= 1'b1;
    wr(BGLC_A_MISC, 8'h00);
    wr(BGLC_A_MISC, 8'h01);
    gap(n);
    gap(n);
    chk(16'(n), 16'd40);
    wr(BGLC_A_TCL, 8'h02);
    wr(BGLC_A_MISC, 8'h00);
    pin_run <= 1'b0;
    wr(BGLC_A_TCL, 8'(tc));
    wr(BGLC_A_MISC, 8'h02);
    foreach (mode_list[i]) begin
      wr(BGLC_A_MODE, mode_list[i]);
      repeat (2) @(negedge clk);
      chk(16'(pin_oe), 16'(i == 0));
    end
    $display("test source done");
    for (int e = 0; e < 4; e++) begin
      wr(BGLC_A_MISC, 8'h02);
      soft_rst <= 1'b1;
      @(posedge clk);
      soft_rst <= 1'b0;
      enc = bglc_enc_e'(e);
      line_lvl = 1'b1;
      txq.delete();
      rxq.delete();
      // Idle high line decodes as one steady FM cell before the first bit
      if (e > 1) rxq.push_back(e == 3);
      wr(BGLC_A_FMT, {1'b0, 2'(e), 5'h00});
      nxt_bit();
      mon_en = 1'b1;
      wr(BGLC_A_MISC, 8'h03);
      repeat (8) @(posedge tx_take);
      mon_en = 1'b0;
      repeat (2 * tc + 8) @(negedge clk);
    end
    wr(BGLC_A_MODE, 8'h08);
    @(posedge tx_take);
    t0 = $time;
    @(posedge tx_take);
    chk(16'(($time - t0) / 10), 16'(2 * BGLC_CM_X16 * (tc + 2)));
    $display("test coding done");
    wr(BGLC_A_MISC, 8'h02);
    wr(BGLC_A_MODE, 8'h01);
    wr(BGLC_A_FMT, 8'h28);
    tx_bit <= 1'b0;
    wr(BGLC_A_MISC, 8'h03);
    repeat (4 * tc + 12) @(posedge clk);
    sdlc_flag_end <= 1'b1;
    @(posedge clk);
    sdlc_flag_end <= 1'b0;
    repeat (4 * tc + 12) @(posedge clk);
    k = 0;
    repeat (4 * tc + 8) begin
      @(negedge clk);
      k += (txd_pin !== 1'b1);
    end
    chk(16'(k), 16'h0000);
    wr(BGLC_A_FMT, 8'h20);
    repeat (4 * tc + 12) @(posedge clk);
    gap(n);
    k = 0;
    bnd_exp = txd_pin;
    repeat (4 * tc + 8) begin
      @(negedge clk);
      k += (txd_pin !== bnd_exp);
      bnd_exp = txd_pin;
    end
    chk(16'(k > 0), 16'h0001);
    $display("test force done");
    test_done();
  end
endmodule
`default_nettype wire
